// >>> include/spf_consts.vh
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH
// byte addresses on the register bus
`define SPF_OFF_CTRL     8'h98
`define SPF_OFF_DATA     8'h99
`define SPF_OFF_PWR      8'h87
`define SPF_OFF_RELOAD   8'hca
`define SPF_OFF_BAUDSRC  8'hc8
`define SPF_OFF_SLAVE_ADDRESS    8'ha9
`define SPF_OFF_SLAVE_ADDRESS_MASK    8'hb9
// serial_control fields
`define SPF_BIT_SM0FE    7
`define SPF_BIT_SM1      6
`define SPF_BIT_AFE      5
`define SPF_BIT_REN      4
`define SPF_BIT_TB8      3
`define SPF_BIT_RB8      2
`define SPF_BIT_TI       1
`define SPF_BIT_RI       0
// power_control fields
`define SPF_BIT_FESEL    6
`define SPF_BIT_DBL      7
// baud source fields
`define SPF_BIT_SRC2     0
`define SPF_BIT_EXTCLK   1
`define SPF_RST_CTRL     8'h00
`define SPF_RST_BYTE     8'h00
`define SPF_RST_RELOAD   16'h0000
// timing: cpu clock per mode-0 bit, mode-2 divisors, oversample
`define SPF_DIV_M0       3'd6
`define SPF_DIV_M2_FAST  6'd16
`define SPF_DIV_M2_SLOW  6'd32
`define SPF_OVERSAMPLE   4'd15
`define SPF_T1_DIV       16'd326
`endif

// >>> hw/spf_tick_div.v
module spf_tick_div (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // control
   input  wire        en,
   input  wire [15:0] period,
   // one-cycle enable out
   output reg         tick_ff
);
   reg [15:0] cnt_ff;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff  <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (!en) begin
         cnt_ff  <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (cnt_ff + 16'h0001 >= period) begin
         cnt_ff  <= 16'h0000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 16'h0001;
         tick_ff <= 1'b0;
      end
   end
endmodule

// >>> hw/spf_reload_timer.v
`include "spf_consts.vh"
// counts up from the reload value; tick on each rollover
module spf_reload_timer (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // control
   input  wire        inc,
   input  wire [15:0] reload,
   // overflow pulse
   output reg         ovf_ff
);
   reg [15:0] cnt_ff;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= `SPF_RST_RELOAD;
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= 1'b0;
         if (inc) begin
            if (cnt_ff == 16'hffff) begin
               cnt_ff <= reload;
               ovf_ff <= 1'b1;
            end else if (cnt_ff < reload) begin
               // a reload above the count applies at once, no long first lap
               cnt_ff <= reload;
            end else begin
               cnt_ff <= cnt_ff + 16'h0001;
            end
         end
      end
   end
endmodule

// >>> hw/spf_serial_port.v
`include "spf_consts.vh"
module spf_serial_port (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // serial line and external timer clock pin
   input  wire        rxd_in,
   output reg         rxd_out_ff,
   output reg         rxd_oe_ff,
   output reg         txd_ff,
   input  wire        timer_external_clock_pin
);
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN  = 2'd1;
   reg  [7:0]  ctrl_ff;
   reg         fe_ff;
   reg         sm0_ff;
   reg  [7:0]  pwr_ff;
   reg  [15:0] reload_ff;
   reg  [1:0]  src_ff;
   reg  [7:0]  slave_address_ff;
   reg  [7:0]  slave_address_mask_ff;
   reg  [7:0]  rbuf_ff;
   reg  [7:0]  aw_ff;
   reg  [31:0] wd_ff;
   reg         awh_ff;
   reg         wh_ff;
   reg         t2pin_ff;
   reg  [1:0]  tst_ff;
   reg  [10:0] tsh_ff;
   reg  [3:0]  tbit_ff;
   reg  [3:0]  tph_ff;
   reg  [1:0]  rst_ff;
   reg  [9:0]  rsh_ff;
   reg  [3:0]  rbit_ff;
   reg  [3:0]  rph_ff;
   reg  [2:0]  smp_ff;
   reg         rxd_d_ff;
   wire [1:0]  mode = {sm0_ff, ctrl_ff[`SPF_BIT_SM1]};
   wire        fesel = pwr_ff[`SPF_BIT_FESEL];
   wire        wr_go = awh_ff && wh_ff && !s_axi_bvalid;
   wire        m0_tick;
   wire        m2_tick;
   wire        t1_tick;
   wire        t2_inc;
   wire        t2_ovf;
   wire        t2_x16;
   wire        os_tick;
   // mode 0: clock/6 per bit, shift clock toggles on half bits
   spf_tick_div u_m0 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
      .period(16'h0003), .tick_ff(m0_tick));
   // mode 2: 16x sample tick at clock/1 or clock/2, so bit is /16 or /32
   spf_tick_div u_m2 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
      .period(pwr_ff[`SPF_BIT_DBL] ? 16'h0001 : 16'h0002), .tick_ff(m2_tick));
   // primary timer stands in as a fixed divider
   spf_tick_div u_t1 (.aclk(aclk), .aresetn(aresetn), .en(1'b1),
      .period(`SPF_T1_DIV), .tick_ff(t1_tick));
   // secondary timer counts clock or external pin edges
   assign t2_inc = src_ff[`SPF_BIT_EXTCLK] ? (timer_external_clock_pin && !t2pin_ff) : 1'b1;
   spf_reload_timer u_t2 (.aclk(aclk), .aresetn(aresetn), .inc(t2_inc),
      .reload(reload_ff), .ovf_ff(t2_ovf));
   // overflow is already the 16x sample tick: bit = overflow/16
   assign t2_x16 = t2_ovf;
   assign os_tick = (mode == 2'b10) ? m2_tick :
                    (src_ff[`SPF_BIT_SRC2] ? t2_x16 : t1_tick);
   // axi write path
   always @(posedge aclk) begin
      if (!aresetn) begin
         awh_ff        <= 1'b0;
         wh_ff         <= 1'b0;
         aw_ff         <= 8'h00;
         wd_ff         <= 32'h0000_0000;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awh_ff        <= 1'b1;
            aw_ff         <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wh_ff        <= 1'b1;
            wd_ff        <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awh_ff        <= 1'b0;
            wh_ff         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end
   // axi read path
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'b00;
         case (s_axi_araddr)
            `SPF_OFF_CTRL:    s_axi_rdata <= {24'h00_0000, fesel ? fe_ff : sm0_ff,
                                              ctrl_ff[6:0]};
            `SPF_OFF_DATA:    s_axi_rdata <= {24'h00_0000, rbuf_ff};
            `SPF_OFF_PWR:     s_axi_rdata <= {24'h00_0000, pwr_ff};
            `SPF_OFF_RELOAD:  s_axi_rdata <= {16'h0000, reload_ff};
            `SPF_OFF_BAUDSRC: s_axi_rdata <= {30'h0000_0000, src_ff};
            `SPF_OFF_SLAVE_ADDRESS:   s_axi_rdata <= {24'h00_0000, slave_address_ff};
            `SPF_OFF_SLAVE_ADDRESS_MASK:   s_axi_rdata <= {24'h00_0000, slave_address_mask_ff};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
   // address filter match for 9-bit frames
   wire [7:0] given = slave_address_ff & slave_address_mask_ff;
   wire [7:0] bcast = slave_address_ff | slave_address_mask_ff;
   // framed modes leave data in [8:1], mode 0 in [9:2]
   wire [7:0] rx_byte = (mode == 2'b00) ? rsh_ff[9:2] : rsh_ff[8:1];
   wire       adr_hit = ((rx_byte & slave_address_mask_ff) == given) ||
                        ((rx_byte & bcast) == bcast);
   // receive completion and filters
   wire       rx_nin = rsh_ff[9];
   wire       flt_ok = !ctrl_ff[`SPF_BIT_AFE] ||
                       ((mode == 2'b01) ? rx_nin : (rx_nin && adr_hit));
   reg        rx_done;
   reg        rx_load;
   reg        tx_done;
   reg        fe_set;
   // register file and flags
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff   <= `SPF_RST_CTRL;
         sm0_ff    <= 1'b0;
         fe_ff     <= 1'b0;
         pwr_ff    <= `SPF_RST_BYTE;
         reload_ff <= `SPF_RST_RELOAD;
         src_ff    <= 2'b00;
         slave_address_ff  <= `SPF_RST_BYTE;
         slave_address_mask_ff  <= `SPF_RST_BYTE;
         rbuf_ff   <= `SPF_RST_BYTE;
         t2pin_ff  <= 1'b0;
      end else begin
         t2pin_ff <= timer_external_clock_pin;
         if (wr_go) begin
            case (aw_ff)
               `SPF_OFF_CTRL: begin
                  ctrl_ff[6:0] <= wd_ff[6:0];
                  if (fesel)
                     fe_ff <= wd_ff[7];
                  else
                     sm0_ff <= wd_ff[7];
               end
               `SPF_OFF_PWR:     pwr_ff    <= wd_ff[7:0];
               `SPF_OFF_RELOAD:  reload_ff <= wd_ff[15:0];
               `SPF_OFF_BAUDSRC: src_ff    <= wd_ff[1:0];
               `SPF_OFF_SLAVE_ADDRESS:   slave_address_ff  <= wd_ff[7:0];
               `SPF_OFF_SLAVE_ADDRESS_MASK:   slave_address_mask_ff  <= wd_ff[7:0];
               default: ;
            endcase
         end
         // hardware set wins over a clearing write in the same cycle
         if (tx_done)
            ctrl_ff[`SPF_BIT_TI] <= 1'b1;
         if (rx_load) begin
            ctrl_ff[`SPF_BIT_RI] <= 1'b1;
            rbuf_ff <= rx_byte;
            if (mode != 2'b00)
               ctrl_ff[`SPF_BIT_RB8] <= rx_nin;
         end
         if (fe_set)
            fe_ff <= 1'b1;
      end
   end
   wire tx_start = wr_go && aw_ff == `SPF_OFF_DATA && tst_ff == ST_IDLE;
   wire [3:0] tx_bits = (mode == 2'b00) ? 4'd8 : (mode == 2'b01) ? 4'd10 : 4'd11;
   // transmitter
   always @(posedge aclk) begin
      if (!aresetn) begin
         tst_ff  <= ST_IDLE;
         tsh_ff  <= 11'h7ff;
         tbit_ff <= 4'h0;
         tph_ff  <= 4'h0;
         txd_ff  <= 1'b1;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         case (tst_ff)
            ST_IDLE: begin
               if (tx_start) begin
                  tst_ff  <= ST_RUN;
                  tbit_ff <= 4'h0;
                  tph_ff  <= 4'h0;
                  if (mode == 2'b00)
                     tsh_ff <= {3'b111, wd_ff[7:0]};
                  else if (mode == 2'b01)
                     tsh_ff <= {2'b11, wd_ff[7:0], 1'b0};
                  else
                     tsh_ff <= {1'b1, ctrl_ff[`SPF_BIT_TB8], wd_ff[7:0], 1'b0};
               end
               if (rst_ff == ST_IDLE)
                  txd_ff <= 1'b1;
               else if (mode == 2'b00 && m0_tick)
                  txd_ff <= rph_ff[0];
            end
            ST_RUN: begin
               if (mode == 2'b00) begin
                  // shift clock on txd: low half then high half of each bit
                  if (m0_tick) begin
                     tph_ff[0] <= ~tph_ff[0];
                     txd_ff    <= tph_ff[0];
                     if (tph_ff[0]) begin
                        tsh_ff  <= {1'b1, tsh_ff[10:1]};
                        tbit_ff <= tbit_ff + 4'h1;
                        if (tbit_ff == 4'd7) begin
                           tst_ff  <= ST_IDLE;
                           tx_done <= 1'b1;
                        end
                     end
                  end
               end else if (os_tick) begin
                  txd_ff <= tsh_ff[0];
                  tph_ff <= tph_ff + 4'h1;
                  if (tph_ff == `SPF_OVERSAMPLE) begin
                     tsh_ff  <= {1'b1, tsh_ff[10:1]};
                     tbit_ff <= tbit_ff + 4'h1;
                     if (tbit_ff == tx_bits - 4'd2 && tph_ff == `SPF_OVERSAMPLE)
                        tx_done <= 1'b1;
                     if (tbit_ff == tx_bits - 4'd1)
                        tst_ff <= ST_IDLE;
                  end
               end
            end
            default: tst_ff <= ST_IDLE;
         endcase
      end
   end
   // rxd driven in mode 0 transmit, else receive
   always @(posedge aclk) begin
      if (!aresetn) begin
         rxd_out_ff <= 1'b1;
         rxd_oe_ff  <= 1'b0;
      end else begin
         rxd_out_ff <= tsh_ff[0];
         rxd_oe_ff  <= (mode == 2'b00) && (tst_ff == ST_RUN);
      end
   end
   wire maj = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) | (smp_ff[0] & smp_ff[2]);
   wire [3:0] rx_bits = (mode == 2'b01) ? 4'd10 : 4'd11;
   // receiver
   always @(posedge aclk) begin
      if (!aresetn) begin
         rst_ff   <= ST_IDLE;
         rsh_ff   <= 10'h000;
         rbit_ff  <= 4'h0;
         rph_ff   <= 4'h0;
         smp_ff   <= 3'b111;
         rxd_d_ff <= 1'b1;
         rx_load  <= 1'b0;
         fe_set   <= 1'b0;
      end else begin
         rx_load  <= 1'b0;
         fe_set   <= 1'b0;
         rxd_d_ff <= rxd_in;
         case (rst_ff)
            ST_IDLE: begin
               rbit_ff <= 4'h0;
               rph_ff  <= 4'h0;
               if (ctrl_ff[`SPF_BIT_REN]) begin
                  if (mode == 2'b00) begin
                     if (!ctrl_ff[`SPF_BIT_RI] && tst_ff == ST_IDLE)
                        rst_ff <= ST_RUN;
                  end else if (rxd_d_ff && !rxd_in) begin
                     rst_ff <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (!ctrl_ff[`SPF_BIT_REN]) begin
                  rst_ff <= ST_IDLE;
               end else if (mode == 2'b00) begin
                  if (m0_tick) begin
                     rph_ff[0] <= ~rph_ff[0];
                     // sample on the rising half of the shift clock
                     if (rph_ff[0]) begin
                        rsh_ff  <= {rxd_in, rsh_ff[9:1]};
                        rbit_ff <= rbit_ff + 4'h1;
                        if (rbit_ff == 4'd7) begin
                           rst_ff  <= ST_IDLE;
                           rx_load <= 1'b1;
                        end
                     end
                  end
               end else if (os_tick) begin
                  rph_ff <= rph_ff + 4'h1;
                  if (rph_ff >= 4'd6 && rph_ff <= 4'd8)
                     smp_ff <= {rxd_in, smp_ff[2:1]};
                  if (rph_ff == `SPF_OVERSAMPLE) begin
                     rbit_ff <= rbit_ff + 4'h1;
                     if (rbit_ff == 4'h0) begin
                        if (maj)
                           rst_ff <= ST_IDLE;
                     end else begin
                        rsh_ff <= {maj, rsh_ff[9:1]};
                     end
                  end
                  // stop bit judged at its centre sample; mode 1 also shifts it in here as the final bit
                  if (rbit_ff == rx_bits - 4'd1 && rph_ff == 4'd9) begin
                     rst_ff <= ST_IDLE;
                     if (!maj)
                        fe_set <= 1'b1;
                     if (mode == 2'b01)
                        rsh_ff <= {maj, rsh_ff[9:1]};
                     if (!ctrl_ff[`SPF_BIT_RI] &&
                         ((mode == 2'b01) ? (!ctrl_ff[`SPF_BIT_AFE] || maj) : flt_ok))
                        rx_load <= 1'b1;
                  end
               end
            end
            default: rst_ff <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> verif/spf_props.sv
`include "spf_consts.vh"
module spf_props (
   // clock and reset
   input logic        aclk,
   input logic        aresetn,
   // register bus
   input logic [7:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   // serial line
   input logic        rxd_oe_ff,
   input logic        txd_ff
);
   // shadow of mode and power bits, taken when address and data go together
   logic       wr_ok;
   logic [1:0] mode_ff;
   logic       fesel_ff;
   logic       dbl_ff;
   logic       prev_ff;
   logic [7:0] fc_ff;
   assign wr_ok = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   always_ff @(posedge aclk) begin
      prev_ff <= txd_ff;
      if (!aresetn) begin
         mode_ff  <= 2'h0;
         fesel_ff <= 1'b0;
         dbl_ff   <= 1'b0;
         fc_ff    <= 8'h00;
      end else begin
         if (wr_ok && s_axi_awaddr == `SPF_OFF_CTRL) begin
            mode_ff[0] <= s_axi_wdata[6];
            // bit 7 is the error flag while the select is set
            if (!fesel_ff) mode_ff[1] <= s_axi_wdata[7];
         end
         if (wr_ok && s_axi_awaddr == `SPF_OFF_PWR) begin
            fesel_ff <= s_axi_wdata[6];
            dbl_ff   <= s_axi_wdata[7];
         end
         // cycles into a fixed-rate frame; 11 bits of 16 cycles
         if (fc_ff != 8'h00) fc_ff <= (fc_ff == 8'haf) ? 8'h00 : fc_ff + 8'h01;
         else if (prev_ff && !txd_ff && mode_ff == 2'h2) fc_ff <= 8'h01;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   oe_mode0_a: assert property (mode_ff != 2'h0 |-> !rxd_oe_ff)
      else $error("rx line driven outside shift mode");
   shift_clk_a: assert property (mode_ff == 2'h0 && $fell(txd_ff) |-> !txd_ff[*3] ##1 txd_ff)
      else $error("shift clock low phase not 3 cycles");
   bit_time_a: assert property (mode_ff == 2'h2 && dbl_ff && fc_ff != 8'h00
      && txd_ff != $past(txd_ff) |-> fc_ff[3:0] == 4'h0)
      else $error("fixed-rate bit edge off the 16 cycle grid");
   rst_idle_a: assert property ($rose(aresetn) |-> txd_ff && s_axi_awready && !s_axi_bvalid)
      else $error("state after reset wrong");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rresp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
      else $error("read response code illegal");
   cover property (mode_ff == 2'h0 && $fell(txd_ff));
   cover property (fc_ff == 8'haf);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind spf_serial_port spf_props spf_props_inst (.*);

// >>> verif/spf_remote_node.sv
module spf_remote_node (
   // clock
   input  logic aclk,
   // serial line
   input  logic txd_ff,
   output logic line_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   // released line rests at its pull-up level
   initial line_ff = 1'b1;
   task automatic send(input logic [8:0] d, input int nb, input logic stp, input int per);
      line_ff <= 1'b0;
      repeat (per) @(posedge aclk);
      for (int i = 0; i < nb; i++) begin
         line_ff <= d[i];
         repeat (per) @(posedge aclk);
      end
      line_ff <= stp;
      repeat (per) @(posedge aclk);
      line_ff <= 1'b1;
   endtask
   // samples start, 9 data and stop in the middle of each bit
   task automatic capture(input int per, output logic [10:0] b, output int n);
      n = 0;
      b = 11'h7ff;
      while (txd_ff !== 1'b0 && n < 4000) begin
         @(posedge aclk);
         n++;
      end
      repeat (per / 2) @(posedge aclk);
      for (int i = 0; i < 11; i++) begin
         b[i] = txd_ff;
         repeat (per) @(posedge aclk);
      end
   endtask
endmodule

// >>> verif/testbench.sv
`include "spf_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b1;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b1;
   logic        rxd_in;
   logic        rxd_out_ff;
   logic        rxd_oe_ff;
   logic        txd_ff;
   logic        node_line;
   logic        timer_external_clock_pin = 1'b0;
   int          n_fail = 0;
   int          n_compared = 0;
   always #5 aclk = ~aclk;
   // the device wins the rx wire only while it drives it
   assign rxd_in = rxd_oe_ff ? rxd_out_ff : node_line;
   spf_serial_port spf_serial_port_inst (.*);
   spf_remote_node spf_remote_node_inst (.aclk(aclk), .txd_ff(txd_ff), .line_ff(node_line));
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      print_verdict();
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      if (n >= 50) hang();
   endtask
   task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp,
                             input logic [1:0] resp);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      if (n >= 50) hang();
      check(what, exp, s_axi_rdata);
      check("read resp", {30'h0, resp}, {30'h0, s_axi_rresp});
   endtask
   // follows the shift clock; samples the rx wire at each rising edge
   task automatic cap0(output logic [7:0] got, output int span);
      int n;
      int t0;
      n = 0;
      t0 = 0;
      got = 8'h00;
      for (int i = 0; i < 8; i++) begin
         while (txd_ff !== 1'b0 && n < 500) begin
            @(posedge aclk);
            n++;
         end
         while (txd_ff !== 1'b1 && n < 500) begin
            @(posedge aclk);
            n++;
         end
         got[i] = rxd_in;
         if (i == 0) t0 = n;
      end
      span = n - t0;
      if (n >= 500) hang();
   endtask
   // capture runs beside the write so the first bit is never missed
   task automatic sc_mode0_tx();
      logic [7:0] got;
      int span;
      fork
         axi_write(`SPF_OFF_DATA, 32'h0000_005a);
         cap0(got, span);
      join
      check("mode0 byte", 32'h0000_005a, {24'h00_0000, got});
      check("mode0 span", 32'h0000_002a, 32'(span));
      repeat (6) @(posedge aclk);
      expect_reg("mode0 done", `SPF_OFF_CTRL, 32'h0000_0002, 2'h0);
   endtask
   task automatic sc_tx(input logic [7:0] ctl, input logic [7:0] d, input int per);
      logic [10:0] fb;
      int wt;
      axi_write(`SPF_OFF_CTRL, {24'h00_0000, ctl});
      fork
         axi_write(`SPF_OFF_DATA, {24'h00_0000, d});
         spf_remote_node_inst.capture(per, fb, wt);
      join
      if (wt >= 4000) hang();
      check("frame bits", {21'h0, 1'b1, ctl[3], d, 1'b0}, {21'h0, fb});
      repeat (per) @(posedge aclk);
      expect_reg("tx done", `SPF_OFF_CTRL, {24'h00_0000, ctl | 8'h02}, 2'h0);
   endtask
   task automatic sc_rx(input logic [7:0] ctl, input logic [8:0] d, input int nb,
                        input logic stp, input int per, input logic [7:0] exp);
      axi_write(`SPF_OFF_CTRL, {24'h00_0000, ctl});
      spf_remote_node_inst.send(d, nb, stp, per);
      expect_reg("ctrl after rx", `SPF_OFF_CTRL, {24'h00_0000, exp}, 2'h0);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      expect_reg("ctrl reset", `SPF_OFF_CTRL, 32'h0000_0000, 2'h0);
      expect_reg("unmapped", 8'h10, 32'h0000_0000, 2'h2);
      sc_mode0_tx();
      axi_write(`SPF_OFF_PWR, 32'h0000_0080);
      sc_tx(8'h88, 8'hc3, 16);
      axi_write(`SPF_OFF_PWR, 32'h0000_0000);
      sc_tx(8'h80, 8'h3c, 32);
      axi_write(`SPF_OFF_BAUDSRC, 32'h0000_0001);
      axi_write(`SPF_OFF_RELOAD, 32'h0000_fffe);
      sc_tx(8'hc8, 8'h81, 32);
      axi_write(`SPF_OFF_PWR, 32'h0000_0080);
      sc_rx(8'h80, 9'h1a5, 9, 1'b1, 16, 8'h80);
      sc_rx(8'h90, 9'h1a5, 9, 1'b1, 16, 8'h95);
      expect_reg("rx data", `SPF_OFF_DATA, 32'h0000_00a5, 2'h0);
      sc_rx(8'hb0, 9'h05a, 9, 1'b1, 16, 8'hb0);
      expect_reg("rx data kept", `SPF_OFF_DATA, 32'h0000_00a5, 2'h0);
      sc_rx(8'hb0, 9'h13c, 9, 1'b1, 16, 8'hb5);
      sc_rx(8'h70, 9'h0c3, 8, 1'b0, 32, 8'h70);
      sc_rx(8'h50, 9'h0c3, 8, 1'b1, 32, 8'h55);
      expect_reg("mode1 data", `SPF_OFF_DATA, 32'h0000_00c3, 2'h0);
      axi_write(`SPF_OFF_PWR, 32'h0000_0040);
      sc_rx(8'h50, 9'h0c3, 8, 1'b0, 32, 8'hd1);
      print_verdict();
   end
endmodule
